//--- hw/ezl_map.svh
// Constants for the exit error and cross-zone logic: sizes, timing and phase codes.
`ifndef EZL_MAP_SVH
`define EZL_MAP_SVH

`define EZL_NZONE          16
`define EZL_NPAIR          4
`define EZL_ZIDX_W         4
`define EZL_SEC_W          9
`define EZL_CLK_PERIOD_NS  4
`define EZL_TICK_PERIOD_NS 1000000000
`define EZL_SEC_PER_MIN    60
`define EZL_XZ_WINDOW_MIN  5
`define EZL_RECENT_MIN     5
`define EZL_EXIT_RESET_S   60
`define EZL_PHASE_IDLE     2'h0
`define EZL_PHASE_WINDOW   2'h1
`define EZL_PHASE_USED     2'h2

`endif

//--- hw/ezl_pkg.sv
// Types shared by the exit error and cross-zone logic.
`include "ezl_map.svh"
package ezl_pkg;
  typedef logic [`EZL_NZONE-1:0]            ezl_zmask_t;
  typedef logic [`EZL_SEC_W-1:0]            ezl_sec_t;
  typedef logic [`EZL_NPAIR-1:0]            ezl_pmask_t;
  typedef logic [`EZL_NPAIR*`EZL_ZIDX_W-1:0] ezl_pidx_t;
  typedef enum logic [2:0] {
    EZL_DISARMED,
    EZL_EXIT,
    EZL_EXIT_ERR,
    EZL_ARMED,
    EZL_ENTRY
  } ezl_state_t;
endpackage : ezl_pkg

//--- hw/ezl_top.sv
// Exit error, recent close, exit delay reset and cross-zone logic of one partition.
`timescale 1ns/1ps
`default_nettype none
`include "ezl_map.svh"
module ezl_top #(
  parameter int unsigned TICK_CYCLES = `EZL_TICK_PERIOD_NS / `EZL_CLK_PERIOD_NS
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             arm_i,
  input  wire logic             disarm_i,
  input  wire logic             exit_err_en_i,
  input  wire logic             exit_rst_en_i,
  input  wire logic             hs_format_i,
  input  wire ezl_pkg::ezl_sec_t   exit_delay_s_i,
  input  wire ezl_pkg::ezl_sec_t   entry_delay_s_i,
  input  wire ezl_pkg::ezl_zmask_t zone_fault_i,
  input  wire ezl_pkg::ezl_zmask_t zone_entry_i,
  input  wire ezl_pkg::ezl_zmask_t zone_interior_i,
  input  wire ezl_pkg::ezl_zmask_t zone_bypass_i,
  input  wire ezl_pkg::ezl_zmask_t zone_resp0_i,
  input  wire ezl_pkg::ezl_pmask_t xz_en_i,
  input  wire ezl_pkg::ezl_pidx_t  xz_first_i,
  input  wire ezl_pkg::ezl_pidx_t  xz_second_i,
  output logic                  armed_o,
  output logic                  exit_delay_o,
  output logic                  entry_delay_o,
  output logic                  sounder_o,
  output ezl_pkg::ezl_zmask_t   auto_bypass_o,
  output ezl_pkg::ezl_zmask_t   zone_alarm_o,
  output ezl_pkg::ezl_pmask_t   relay_fault_o,
  output ezl_pkg::ezl_pmask_t   relay_alarm_o,
  output logic                  rpt_exit_user_o,
  output logic                  rpt_exit_zone_o,
  output logic                  rpt_zone_alarm_o,
  output logic                  rpt_bypass_o,
  output logic                  rpt_recent_close_o
);
  import ezl_pkg::*;

  localparam int       TW        = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam ezl_sec_t RECENT_S  = ezl_sec_t'(`EZL_RECENT_MIN * `EZL_SEC_PER_MIN);
  localparam ezl_sec_t EXIT_RS_S = ezl_sec_t'(`EZL_EXIT_RESET_S);

  // ------------------------------------------------------------
  // Input synchronisers, edges and the seconds tick
  // ------------------------------------------------------------
  ezl_zmask_t    flt_s1_ff, flt_s2_ff, flt_d_ff;
  logic [TW-1:0] tick_cnt_ff;
  wire           tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
  wire ezl_zmask_t rise = flt_s2_ff & ~flt_d_ff;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      flt_s1_ff   <= '0;
      flt_s2_ff   <= '0;
      flt_d_ff    <= '0;
      tick_cnt_ff <= '0;
    end else if (ce_i) begin
      flt_s1_ff   <= zone_fault_i;
      flt_s2_ff   <= flt_s1_ff;
      flt_d_ff    <= flt_s2_ff;
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Zone conditions
  // ------------------------------------------------------------
  ezl_state_t st_ff, nxt_st;
  ezl_sec_t   timer_ff, nxt_timer, rc_ff, nxt_rc;
  logic [1:0] phase_ff, nxt_phase;
  logic       door_seen_ff, nxt_door_seen;
  ezl_zmask_t auto_byp_ff, nxt_auto_byp, alarm_ff, alarm_v, xz_mask;
  logic       ent_to;
  logic [4:0] rpt_ff, nxt_rpt;

  wire ezl_zmask_t byp        = zone_bypass_i | auto_byp_ff;
  wire ezl_zmask_t live       = flt_s2_ff & ~byp;
  wire ezl_zmask_t err_zones  = live & (zone_entry_i | zone_interior_i);
  wire             door_fault = |(live & zone_entry_i);
  wire             int_fault  = |(live & zone_interior_i);
  wire             door_rise  = |(rise & ~byp & zone_entry_i);
  wire             timer_zero = (timer_ff == '0);
  wire             watching   = (st_ff == EZL_ARMED) || (st_ff == EZL_ENTRY);
  // Interior followers are quiet while the entry delay runs.
  wire ezl_zmask_t follow_mask = (st_ff == EZL_ENTRY) ? zone_interior_i : '0;
  wire ezl_zmask_t cand = rise & ~byp & ~zone_resp0_i & ~zone_entry_i & ~follow_mask & {`EZL_NZONE{watching}};

  // ------------------------------------------------------------
  // Cross-zone pairs
  // ------------------------------------------------------------
  ezl_pmask_t xp_act, xp_a, xp_b;

  for (genvar p = 0; p < `EZL_NPAIR; p++) begin : g_pair
    wire [`EZL_ZIDX_W-1:0] ia = xz_first_i[p*`EZL_ZIDX_W +: `EZL_ZIDX_W];
    wire [`EZL_ZIDX_W-1:0] ib = xz_second_i[p*`EZL_ZIDX_W +: `EZL_ZIDX_W];
    assign xp_act[p] = xz_en_i[p] & ~byp[ia] & ~byp[ib] & ~zone_resp0_i[ia] & ~zone_resp0_i[ib];
    assign relay_fault_o[p] = xz_en_i[p] & (flt_s2_ff[ia] | flt_s2_ff[ib]);
    ezl_xpair u_xpair (
      .mclk_i        (mclk_i),
      .rst_i         (rst_i),
      .ce_i          (ce_i),
      .tick_i        (tick),
      .active_i      (xp_act[p]),
      .fault_a_i     (flt_s2_ff[ia]),
      .fault_b_i     (flt_s2_ff[ib]),
      .rise_a_i      (cand[ia]),
      .rise_b_i      (cand[ib]),
      .alarm_a_o     (xp_a[p]),
      .alarm_b_o     (xp_b[p]),
      .relay_alarm_o (relay_alarm_o[p])
    );
  end

  always_comb begin
    xz_mask = '0;
    for (int p = 0; p < `EZL_NPAIR; p++) begin
      if (xp_act[p]) begin
        xz_mask[xz_first_i[p*`EZL_ZIDX_W +: `EZL_ZIDX_W]]  = 1'b1;
        xz_mask[xz_second_i[p*`EZL_ZIDX_W +: `EZL_ZIDX_W]] = 1'b1;
      end
    end
    alarm_v = (cand & ~xz_mask) | (ent_to ? (live & zone_entry_i) : '0);
    for (int p = 0; p < `EZL_NPAIR; p++) begin
      alarm_v[xz_first_i[p*`EZL_ZIDX_W +: `EZL_ZIDX_W]]  |= xp_a[p];
      alarm_v[xz_second_i[p*`EZL_ZIDX_W +: `EZL_ZIDX_W]] |= xp_b[p];
    end
  end

  // ------------------------------------------------------------
  // Arming sequence
  // ------------------------------------------------------------
  always_comb begin
    nxt_st        = st_ff;
    nxt_timer     = (tick && !timer_zero) ? timer_ff - 1'b1 : timer_ff;
    nxt_rc        = (tick && rc_ff != '0) ? rc_ff - 1'b1 : rc_ff;
    nxt_phase     = phase_ff;
    nxt_door_seen = door_seen_ff;
    nxt_auto_byp  = auto_byp_ff;
    nxt_rpt       = 5'h00;
    ent_to        = 1'b0;
    if (disarm_i) begin
      nxt_st       = EZL_DISARMED;
      nxt_timer    = '0;
      nxt_rc       = '0;
      nxt_phase    = `EZL_PHASE_IDLE;
      nxt_auto_byp = '0;
    end else begin
      unique case (st_ff)
        EZL_DISARMED: begin
          if (arm_i) begin
            nxt_st        = EZL_EXIT;
            nxt_timer     = exit_delay_s_i;
            nxt_rc        = RECENT_S;
            nxt_phase     = `EZL_PHASE_IDLE;
            nxt_door_seen = 1'b0;
          end
        end
        EZL_EXIT: begin
          if (door_fault) begin
            nxt_door_seen = 1'b1;
          end
          if (exit_rst_en_i && phase_ff == `EZL_PHASE_IDLE && door_seen_ff && !door_fault) begin
            nxt_timer = EXIT_RS_S;
            nxt_phase = `EZL_PHASE_WINDOW;
          end else if (phase_ff == `EZL_PHASE_WINDOW && door_rise) begin
            nxt_timer = exit_delay_s_i;
            nxt_phase = `EZL_PHASE_USED;
          end else if (timer_zero) begin
            if (exit_err_en_i && (door_fault || int_fault)) begin
              nxt_st    = EZL_EXIT_ERR;
              nxt_timer = entry_delay_s_i;
            end else if (door_fault || int_fault) begin
              nxt_st    = EZL_ENTRY;
              nxt_timer = entry_delay_s_i;
            end else begin
              nxt_st = EZL_ARMED;
            end
          end
        end
        EZL_EXIT_ERR: begin
          if (timer_zero) begin
            nxt_st       = EZL_ARMED;
            nxt_auto_byp = auto_byp_ff | err_zones;
            // Order: exit user, exit zone, zone alarm, bypass, recent close.
            nxt_rpt      = {!hs_format_i, !hs_format_i, hs_format_i, 1'b1, 1'b0};
          end
        end
        EZL_ARMED: begin
          if (door_rise) begin
            nxt_st    = EZL_ENTRY;
            nxt_timer = entry_delay_s_i;
          end
        end
        EZL_ENTRY: begin
          if (timer_zero) begin
            ent_to = 1'b1;
            nxt_st = EZL_ARMED;
          end
        end
      endcase
    end
    if (|alarm_v && rc_ff != '0) begin
      nxt_rpt[0] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff        <= EZL_DISARMED;
      timer_ff     <= '0;
      rc_ff        <= '0;
      phase_ff     <= `EZL_PHASE_IDLE;
      door_seen_ff <= 1'b0;
      auto_byp_ff  <= '0;
      alarm_ff     <= '0;
      rpt_ff       <= 5'h00;
    end else if (ce_i) begin
      st_ff        <= nxt_st;
      timer_ff     <= nxt_timer;
      rc_ff        <= nxt_rc;
      phase_ff     <= nxt_phase;
      door_seen_ff <= nxt_door_seen;
      auto_byp_ff  <= nxt_auto_byp;
      alarm_ff     <= alarm_v;
      rpt_ff       <= nxt_rpt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign armed_o            = (st_ff == EZL_ARMED) || (st_ff == EZL_ENTRY);
  assign exit_delay_o       = (st_ff == EZL_EXIT);
  assign entry_delay_o      = (st_ff == EZL_ENTRY) || (st_ff == EZL_EXIT_ERR);
  assign sounder_o          = (st_ff == EZL_EXIT_ERR);
  assign auto_bypass_o      = auto_byp_ff;
  assign zone_alarm_o       = alarm_ff;
  assign rpt_exit_user_o    = rpt_ff[4];
  assign rpt_exit_zone_o    = rpt_ff[3];
  assign rpt_zone_alarm_o   = rpt_ff[2];
  assign rpt_bypass_o       = rpt_ff[1];
  assign rpt_recent_close_o = rpt_ff[0];
endmodule // ezl_top
`default_nettype wire

//--- hw/ezl_xpair.sv
// One cross-zone pair: qualification window, long-fault hold and pair relay.
`timescale 1ns/1ps
`default_nettype none
`include "ezl_map.svh"
module ezl_xpair (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic tick_i,
  input  wire logic active_i,
  input  wire logic fault_a_i,
  input  wire logic fault_b_i,
  input  wire logic rise_a_i,
  input  wire logic rise_b_i,
  output logic      alarm_a_o,
  output logic      alarm_b_o,
  output logic      relay_alarm_o
);
  import ezl_pkg::*;

  localparam ezl_sec_t WIN_S = ezl_sec_t'(`EZL_XZ_WINDOW_MIN * `EZL_SEC_PER_MIN);

  ezl_sec_t win_a_ff, win_b_ff, hold_a_ff, hold_b_ff;
  logic     pend_b_ff, relay_ff;
  wire      recent_a = (win_a_ff != '0) || (hold_a_ff == WIN_S);
  wire      recent_b = (win_b_ff != '0) || (hold_b_ff == WIN_S);
  wire      qual     = active_i & ((rise_a_i & (recent_b | rise_b_i)) | (rise_b_i & recent_a));
  wire      rly_set  = active_i ? qual : (rise_a_i | rise_b_i);

  // On an active pair the first zone alarms at once, the second one cycle later; otherwise each alarms at once on its own rise.
  assign alarm_a_o     = active_i ? qual : rise_a_i;
  assign alarm_b_o     = active_i ? pend_b_ff : rise_b_i;
  assign relay_alarm_o = relay_ff;

  wire ezl_sec_t nxt_win_a  = rise_a_i ? WIN_S : ((tick_i && win_a_ff != '0) ? win_a_ff - 1'b1 : win_a_ff);
  wire ezl_sec_t nxt_win_b  = rise_b_i ? WIN_S : ((tick_i && win_b_ff != '0) ? win_b_ff - 1'b1 : win_b_ff);
  wire ezl_sec_t nxt_hold_a = !fault_a_i ? '0 : ((tick_i && hold_a_ff != WIN_S) ? hold_a_ff + 1'b1 : hold_a_ff);
  wire ezl_sec_t nxt_hold_b = !fault_b_i ? '0 : ((tick_i && hold_b_ff != WIN_S) ? hold_b_ff + 1'b1 : hold_b_ff);
  // Relay stays on until both zones have restored.
  wire           nxt_relay  = rly_set | (relay_ff & (fault_a_i | fault_b_i));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      win_a_ff  <= '0;
      win_b_ff  <= '0;
      hold_a_ff <= '0;
      hold_b_ff <= '0;
      pend_b_ff <= 1'b0;
      relay_ff  <= 1'b0;
    end else if (ce_i) begin
      win_a_ff  <= nxt_win_a;
      win_b_ff  <= nxt_win_b;
      hold_a_ff <= nxt_hold_a;
      hold_b_ff <= nxt_hold_b;
      pend_b_ff <= qual;
      relay_ff  <= nxt_relay;
    end
  end
endmodule // ezl_xpair
`default_nettype wire

//--- sim/ezl_field_model.sv
// Zone loops and report dialer standing at the far side of the block.
`timescale 1ns/1ps
`default_nettype none
module ezl_field_model (
  input  wire logic                mclk_i,
  input  wire ezl_pkg::ezl_zmask_t loop_cmd_i,
  input  wire logic [4:0]          rpt_i,
  output ezl_pkg::ezl_zmask_t      fault_o,
  output logic [4:0][15:0]         cnt_o
);
  import ezl_pkg::*;
  // Loops follow their command one edge late, as a real contact would.
  initial begin
    fault_o = '0;
    cnt_o   = '0;
    forever begin
      @(posedge mclk_i);
      fault_o <= loop_cmd_i;
      for (int i = 0; i < 5; i++) begin
        if (rpt_i[i]) begin
          cnt_o[i] <= cnt_o[i] + 16'h0001;
        end
      end
    end
  end
endmodule // ezl_field_model
`default_nettype wire

//--- sim/ezl_top_monitor.sv
// Port checker for the exit error and cross-zone block.
`timescale 1ns/1ps
`default_nettype none
module ezl_top_monitor #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                mclk_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  input wire logic                disarm_i,
  input wire logic                hs_format_i,
  input wire ezl_pkg::ezl_pmask_t xz_en_i,
  input wire logic                armed_o,
  input wire logic                exit_delay_o,
  input wire logic                entry_delay_o,
  input wire logic                sounder_o,
  input wire ezl_pkg::ezl_zmask_t auto_bypass_o,
  input wire ezl_pkg::ezl_zmask_t zone_alarm_o,
  input wire ezl_pkg::ezl_pmask_t relay_fault_o,
  input wire ezl_pkg::ezl_pmask_t relay_alarm_o,
  input wire logic                rpt_exit_user_o,
  input wire logic                rpt_exit_zone_o,
  input wire logic                rpt_bypass_o,
  input wire logic                rpt_recent_close_o
);
  import ezl_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_disarm_clears: assert property (ce_i && disarm_i |=> !armed_o && !exit_delay_o && !sounder_o && auto_bypass_o == '0)
    else $error("disarm left state");
  a_sounder_entry: assert property (sounder_o |-> entry_delay_o && !armed_o)
    else $error("sounder outside entry delay");
  a_hs_no_user: assert property (rpt_exit_user_o || rpt_exit_zone_o |-> !$past(hs_format_i))
    else $error("exit report under fast format");
  a_exit_zone_byp: assert property (rpt_exit_zone_o |-> rpt_bypass_o && armed_o)
    else $error("exit report without bypass");
  a_bypass_armed: assert property (auto_bypass_o != '0 |-> armed_o)
    else $error("auto bypass while not armed");
  a_recent_alarm: assert property (rpt_recent_close_o |-> zone_alarm_o != '0)
    else $error("recent close without alarm");
  a_relay_fault_en: assert property ((relay_fault_o & ~xz_en_i) == '0)
    else $error("fault relay on disabled pair");
  a_alarm_pulse: assert property ($past(ce_i) |-> (zone_alarm_o & $past(zone_alarm_o)) == '0)
    else $error("alarm longer than one cycle");
  a_reset_clears: assert property (disable iff (1'b0) rst_i && ce_i |=> !armed_o && zone_alarm_o == '0 && relay_alarm_o == '0)
    else $error("reset left state");
  c_sounder: cover property (sounder_o);
  c_recent: cover property (rpt_recent_close_o);
  c_relay: cover property (relay_alarm_o != '0);
endmodule // ezl_top_monitor
`default_nettype wire

//--- sim/test_ezl_top.sv
// Self-checking bench for the exit error and cross-zone block.
`timescale 1ns/1ps
`default_nettype none
module test_ezl_top;
  import ezl_pkg::*;
  localparam int TK = 4;
  logic             mclk_i = 0, rst_i = 1, arm = 0, dis = 0, een = 0, ren = 0, hs = 0, ce = 1;
  logic             armed, exd, ent, snd;
  logic [4:0]       rpt;
  logic [4:0][15:0] cnt, b;
  ezl_sec_t         ed = 5, ed2 = 3;
  ezl_zmask_t       cmd = '0, byp = '0, rsp0 = '0, seen = '0, flt, abyp, zal;
  ezl_pmask_t       xe = '0, rf, ra;
  ezl_pidx_t        xf = '0, xs = '0;
  int               n_errors = 0, num_checks = 0, cyc_n = 0, n, z;
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic wt(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
  endtask
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i) seen <= seen | zal;
  always @(posedge mclk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ezl_field_model ezl_field_model_inst (.mclk_i(mclk_i), .loop_cmd_i(cmd), .rpt_i(rpt), .fault_o(flt), .cnt_o(cnt));
  ezl_top #(.TICK_CYCLES(TK)) ezl_top_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .arm_i(arm), .disarm_i(dis), .exit_err_en_i(een),
    .exit_rst_en_i(ren), .hs_format_i(hs), .exit_delay_s_i(ed), .entry_delay_s_i(ed2), .zone_fault_i(flt),
    .zone_entry_i(16'h0001), .zone_interior_i(16'h0002), .zone_bypass_i(byp), .zone_resp0_i(rsp0),
    .xz_en_i(xe), .xz_first_i(xf), .xz_second_i(xs), .armed_o(armed), .exit_delay_o(exd),
    .entry_delay_o(ent), .sounder_o(snd), .auto_bypass_o(abyp), .zone_alarm_o(zal), .relay_fault_o(rf),
    .relay_alarm_o(ra), .rpt_exit_user_o(rpt[0]), .rpt_exit_zone_o(rpt[1]), .rpt_zone_alarm_o(rpt[2]),
    .rpt_bypass_o(rpt[3]), .rpt_recent_close_o(rpt[4]));
  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    z = $urandom(20617);
    ed = ezl_sec_t'(3 + $urandom % 4);
    ed2 = ezl_sec_t'(2 + $urandom % 3);
    xe = 4'hf;
    xf = {4'h8, 4'h6, 4'h4, 4'h2};
    xs = {4'h9, 4'h7, 4'h5, 4'h3};
    cyc(10);
    rst_i = 0;
    cyc(3);
    b = cnt;
    pulse(arm);
    wt(armed);
    chk(n >= (ed - 1) * TK && n <= (ed + 1) * TK + 3, 1);
    cmd[10] = 1;
    cyc(8);
    chk(seen[10], 1);
    chk(cnt[4] - b[4], 1);
    cmd[10] = 0;
    pulse(dis);
    een = 1;
    for (int h = 0; h < 2; h++) begin
      hs = h[0];
      cmd[0] = 1;
      b = cnt;
      pulse(arm);
      wt(snd);
      chk({snd, ent, armed}, 3'b110);
      wt(armed);
      chk(n >= (ed2 - 1) * TK && n <= (ed2 + 1) * TK + 3, 1);
      cyc(2);
      chk(abyp, 16'h0001);
      chk(cnt[0] - b[0], h == 0);
      chk(cnt[1] - b[1], h == 0);
      chk(cnt[3] - b[3], 1);
      chk(cnt[2] != b[2], h == 1);
      cmd[0] = 0;
      pulse(dis);
      cyc(1);
      chk(abyp, 0);
    end
    een = 0;
    ren = 1;
    cmd[0] = 1;
    pulse(arm);
    cyc(4);
    cmd[0] = 0;
    cyc(12 * TK);
    chk(exd, 1);
    cmd[0] = 1;
    cyc(4);
    cmd[0] = 0;
    wt(armed);
    chk(n >= (ed - 2) * TK && n <= (ed + 1) * TK + 3, 1);
    pulse(dis);
    ren = 0;
    pulse(arm);
    wt(armed);
    for (int p = 0; p < 4; p++) begin
      z = 2 + 2 * p;
      seen = '0;
      cmd[z] = 1;
      cyc(4);
      chk({rf[p], ra[p]}, 2'b10);
      cmd[z] = 0;
      cyc(8);
      chk(seen[z], 0);
      cmd[z + 1] = 1;
      cyc(8);
      chk({seen[z], seen[z + 1], ra[p]}, 3'b111);
      cmd[z] = 1;
      cmd[z + 1] = 0;
      cyc(8);
      chk(ra[p], 1);
      cmd[z] = 0;
      cyc(8);
      chk(ra[p], 0);
    end
    cmd[2] = 1;
    cyc(305 * TK);
    seen = '0;
    b = cnt;
    cmd[3] = 1;
    cyc(8);
    chk(seen[3], 1);
    chk(cnt[4] - b[4], 0);
    cmd[3:2] = 2'h0;
    cyc(4);
    for (int k = 0; k < 2; k++) begin
      byp = k ? 16'h0020 : 16'h0000;
      rsp0 = k ? 16'h0000 : 16'h0200;
      z = 8 - 4 * k;
      seen = '0;
      cmd[z] = 1;
      cyc(8);
      chk(seen[z], 1);
      cmd[z] = 0;
      cyc(4);
    end
    // A low clock enable must hold back a new fault until it rises again.
    ce = 0;
    cmd[10] = 1;
    seen = '0;
    cyc(8);
    chk(seen[10], 0);
    ce = 1;
    cyc(8);
    chk(seen[10], 1);
    cmd[10] = 0;
    cyc(4);
    pulse(rst_i);
    chk(armed, 0);
    pulse(dis);
    cyc(1);
    chk(armed, 0);
    tally_and_finish();
  end
endmodule // test_ezl_top
bind ezl_top ezl_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) ezl_top_monitor_inst (.mclk_i, .rst_i, .ce_i, .disarm_i,
  .hs_format_i, .xz_en_i, .armed_o, .exit_delay_o, .entry_delay_o, .sounder_o, .auto_bypass_o, .zone_alarm_o,
  .relay_fault_o, .relay_alarm_o, .rpt_exit_user_o, .rpt_exit_zone_o, .rpt_bypass_o, .rpt_recent_close_o);
`default_nettype wire
